// *** design/irq_prio_pkg.sv ***
// constants for the priority level registers six to ten
// used by the register block and its word module only; the bench hard-codes its values; no other dependencies
package irq_prio_pkg;

  localparam int unsigned NUM_REGS     = 5;
  localparam int unsigned FIELDS_PER   = 4;
  localparam int unsigned LEVEL_W      = 3;
  localparam int unsigned REG_W        = 16;
  localparam int unsigned ADDR_W       = 4;
  localparam int unsigned NUM_SRC      = NUM_REGS * FIELDS_PER;

  // word offsets on the avalon slave, one 32-bit word each
  localparam logic [ADDR_W-1:0] OFF_PRIO_CTRL_6  = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_PRIO_CTRL_7  = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_PRIO_CTRL_8  = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_PRIO_CTRL_9  = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_PRIO_CTRL_10 = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STATUS       = 4'h5;

  // field positions (lsb) inside a register
  localparam int unsigned FLD0_LSB = 0;
  localparam int unsigned FLD1_LSB = 4;
  localparam int unsigned FLD2_LSB = 8;
  localparam int unsigned FLD3_LSB = 12;

  // implemented bits of every register
  localparam logic [REG_W-1:0] IMPL_MASK   = 16'h7777;
  localparam logic [REG_W-1:0] RESET_VALUE = 16'h4444;

  localparam logic [LEVEL_W-1:0] LEVEL_OFF  = 3'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_LOW  = 3'h1;
  localparam logic [LEVEL_W-1:0] LEVEL_HIGH = 3'h7;

  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage

// *** design/irq_prio_regs.sv ***
// priority level registers six to ten of the interrupt controller
// avalon-mm slave on core_clk; arbitration logic reads the level and enable outputs
// Summary of operation
// - A field holding 111 places its source at level seven, the highest.
// - Code 001 is level one, the lowest enabled, and codes between map to levels two to six.
// - Code 000 disables the source so that it never asks for service.
// - Every unimplemented bit reads as zero.
// - After reset each field holds 100, level four.
// - Fields sit at bits 14-12, 10-8, 6-4 and 2-0; bits 15, 11, 7 and 3 are unused.
// - Register six holds timer four, output compare four and three, dma channel two done.
// - Register seven holds uart two transmit and receive, external irq two and timer five.
// - Register eight holds can one events, can one receive ready, spi two events and errors.
// - Register nine holds input capture five, four, three and dma channel three done.
// - Register ten holds output compare seven, six, five and input capture six.
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`default_nettype none

module irq_prio_regs (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // register six
  output logic      [2:0]  timer4_level,
  output logic      [2:0]  outcmp4_level,
  output logic      [2:0]  outcmp3_level,
  output logic      [2:0]  dma_ch2_done_level,
  // register seven
  output logic      [2:0]  uart2_tx_level,
  output logic      [2:0]  uart2_rx_level,
  output logic      [2:0]  ext_irq2_level,
  output logic      [2:0]  timer5_level,
  // register eight
  output logic      [2:0]  can1_event_level,
  output logic      [2:0]  can1_rx_ready_level,
  output logic      [2:0]  spi2_event_level,
  output logic      [2:0]  spi2_error_level,
  // register nine
  output logic      [2:0]  incap5_level,
  output logic      [2:0]  incap4_level,
  output logic      [2:0]  incap3_level,
  output logic      [2:0]  dma_ch3_done_level,
  // register ten
  output logic      [2:0]  outcmp7_level,
  output logic      [2:0]  outcmp6_level,
  output logic      [2:0]  outcmp5_level,
  output logic      [2:0]  incap6_level,
  // per source enable, bit 19 is timer4 down to bit 0 incap6
  output logic      [19:0] src_enable
);

  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_DONE
  } bus_state_e;

  bus_state_e                   bus_state_r;
  bus_state_e                   bus_state_nxt;
  logic [15:0]                  prio_r   [irq_prio_pkg::NUM_REGS];
  logic [3:0]                   en_part  [irq_prio_pkg::NUM_REGS];
  logic [4:0]                   reg_sel;
  logic                         status_sel;
  logic [4:0]                   wr_sel;
  logic [31:0]                  rdata_r;
  logic [31:0]                  rdata_nxt;
  logic                         wait_r;
  logic                         wait_nxt;
  logic [19:0]                  en_all;
  logic [15:0]                  wmask;
  logic                         req;

  assign req   = avs_read | avs_write;
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} & irq_prio_pkg::IMPL_MASK;

  // every offset is decoded by its own name, so the word map need not be consecutive
  always_comb begin
    reg_sel    = 5'h00;
    status_sel = 1'b0;
    case (avs_address)
      irq_prio_pkg::OFF_PRIO_CTRL_6: begin
        reg_sel[0] = 1'b1;
      end
      irq_prio_pkg::OFF_PRIO_CTRL_7: begin
        reg_sel[1] = 1'b1;
      end
      irq_prio_pkg::OFF_PRIO_CTRL_8: begin
        reg_sel[2] = 1'b1;
      end
      irq_prio_pkg::OFF_PRIO_CTRL_9: begin
        reg_sel[3] = 1'b1;
      end
      irq_prio_pkg::OFF_PRIO_CTRL_10: begin
        reg_sel[4] = 1'b1;
      end
      irq_prio_pkg::OFF_STATUS: begin
        status_sel = 1'b1;
      end
      default: begin
        reg_sel    = 5'h00;
        status_sel = 1'b0;
      end
    endcase
  end

  // every access takes one wait cycle, the answer stands at the second edge
  always_comb begin
    bus_state_nxt = bus_state_r;
    wait_nxt      = 1'b1;
    rdata_nxt     = rdata_r;
    wr_sel        = 5'h00;
    case (bus_state_r)
      BUS_IDLE: begin
        if (req) begin
          bus_state_nxt = BUS_DONE;
          wait_nxt      = 1'b0;
          rdata_nxt     = irq_prio_pkg::UNMAPPED_READ;
          // the word takes the write at this edge, so levels move at the same edge that drops waitrequest
          if (avs_write) begin
            wr_sel = reg_sel;
          end
          for (int i = 0; i < irq_prio_pkg::NUM_REGS; i++) begin
            if (reg_sel[i]) begin
              rdata_nxt = {16'h0000, prio_r[i] & irq_prio_pkg::IMPL_MASK};
            end
          end
          if (status_sel) begin
            rdata_nxt = {12'h000, en_all};
          end
        end
      end
      BUS_DONE: begin
        // master releases the request at this edge
        bus_state_nxt = BUS_IDLE;
        wait_nxt      = 1'b1;
      end
      default: begin
        bus_state_nxt = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_r <= BUS_IDLE;
      wait_r      <= 1'b1;
      rdata_r     <= 32'h0000_0000;
    end else begin
      bus_state_r <= bus_state_nxt;
      wait_r      <= wait_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  // one word per register; field three of each word drives the highest enable bit of its group
  irq_prio_word #(
    .RESET_WORD (irq_prio_pkg::RESET_VALUE)
  ) slot6 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (wr_sel[0]),
    .wr_data  (avs_writedata[15:0]),
    .wr_mask  (wmask),
    .word     (prio_r[0]),
    .enable   (en_part[0])
  );

  irq_prio_word #(
    .RESET_WORD (irq_prio_pkg::RESET_VALUE)
  ) slot7 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (wr_sel[1]),
    .wr_data  (avs_writedata[15:0]),
    .wr_mask  (wmask),
    .word     (prio_r[1]),
    .enable   (en_part[1])
  );

  irq_prio_word #(
    .RESET_WORD (irq_prio_pkg::RESET_VALUE)
  ) slot8 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (wr_sel[2]),
    .wr_data  (avs_writedata[15:0]),
    .wr_mask  (wmask),
    .word     (prio_r[2]),
    .enable   (en_part[2])
  );

  irq_prio_word #(
    .RESET_WORD (irq_prio_pkg::RESET_VALUE)
  ) slot9 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (wr_sel[3]),
    .wr_data  (avs_writedata[15:0]),
    .wr_mask  (wmask),
    .word     (prio_r[3]),
    .enable   (en_part[3])
  );

  irq_prio_word #(
    .RESET_WORD (irq_prio_pkg::RESET_VALUE)
  ) slot10 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (wr_sel[4]),
    .wr_data  (avs_writedata[15:0]),
    .wr_mask  (wmask),
    .word     (prio_r[4]),
    .enable   (en_part[4])
  );

  // bit 19 is timer4, bit 0 incap6; every bit comes straight from a word's enable flop
  assign en_all = {en_part[0], en_part[1], en_part[2], en_part[3], en_part[4]};

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign src_enable      = en_all;

  // field layout, high field first; levels are the codes themselves
  assign timer4_level        = prio_r[0][irq_prio_pkg::FLD3_LSB +: 3];
  assign outcmp4_level       = prio_r[0][irq_prio_pkg::FLD2_LSB +: 3];
  assign outcmp3_level       = prio_r[0][irq_prio_pkg::FLD1_LSB +: 3];
  assign dma_ch2_done_level  = prio_r[0][irq_prio_pkg::FLD0_LSB +: 3];
  assign uart2_tx_level      = prio_r[1][irq_prio_pkg::FLD3_LSB +: 3];
  assign uart2_rx_level      = prio_r[1][irq_prio_pkg::FLD2_LSB +: 3];
  assign ext_irq2_level      = prio_r[1][irq_prio_pkg::FLD1_LSB +: 3];
  assign timer5_level        = prio_r[1][irq_prio_pkg::FLD0_LSB +: 3];
  assign can1_event_level    = prio_r[2][irq_prio_pkg::FLD3_LSB +: 3];
  assign can1_rx_ready_level = prio_r[2][irq_prio_pkg::FLD2_LSB +: 3];
  assign spi2_event_level    = prio_r[2][irq_prio_pkg::FLD1_LSB +: 3];
  assign spi2_error_level    = prio_r[2][irq_prio_pkg::FLD0_LSB +: 3];
  assign incap5_level        = prio_r[3][irq_prio_pkg::FLD3_LSB +: 3];
  assign incap4_level        = prio_r[3][irq_prio_pkg::FLD2_LSB +: 3];
  assign incap3_level        = prio_r[3][irq_prio_pkg::FLD1_LSB +: 3];
  assign dma_ch3_done_level  = prio_r[3][irq_prio_pkg::FLD0_LSB +: 3];
  assign outcmp7_level       = prio_r[4][irq_prio_pkg::FLD3_LSB +: 3];
  assign outcmp6_level       = prio_r[4][irq_prio_pkg::FLD2_LSB +: 3];
  assign outcmp5_level       = prio_r[4][irq_prio_pkg::FLD1_LSB +: 3];
  assign incap6_level        = prio_r[4][irq_prio_pkg::FLD0_LSB +: 3];

endmodule

// one priority word: four level fields behind a lane-masked write port
module irq_prio_word #(
  parameter logic [15:0] RESET_WORD = irq_prio_pkg::RESET_VALUE
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // write port, decoded and lane-masked by the bus slave
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic [15:0] wr_mask,
  // stored word and one enable per field, field three first
  output logic      [15:0] word,
  output logic      [3:0]  enable
);

  // a field comes out of reset enabled unless its reset code is 000
  localparam logic [3:0] ENABLE_RESET = {
    RESET_WORD[irq_prio_pkg::FLD3_LSB +: 3] != irq_prio_pkg::LEVEL_OFF,
    RESET_WORD[irq_prio_pkg::FLD2_LSB +: 3] != irq_prio_pkg::LEVEL_OFF,
    RESET_WORD[irq_prio_pkg::FLD1_LSB +: 3] != irq_prio_pkg::LEVEL_OFF,
    RESET_WORD[irq_prio_pkg::FLD0_LSB +: 3] != irq_prio_pkg::LEVEL_OFF
  };

  logic [15:0] word_r;
  logic [15:0] word_nxt;
  logic [3:0]  enable_r;
  logic [3:0]  enable_nxt;

  // unused bits never enter the mask, so they keep the zero they reset to
  always_comb begin
    word_nxt = word_r;
    if (wr_en) begin
      word_nxt = (word_r & ~wr_mask) | (wr_data & wr_mask);
    end
    // taken from the next word so that the enable moves in step with the level
    for (int f = 0; f < irq_prio_pkg::FIELDS_PER; f++) begin
      enable_nxt[f] = (word_nxt[4*f +: 3] != irq_prio_pkg::LEVEL_OFF);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_r   <= RESET_WORD;
      enable_r <= ENABLE_RESET;
    end else begin
      word_r   <= word_nxt;
      enable_r <= enable_nxt;
    end
  end

  assign word   = word_r;
  assign enable = enable_r;

endmodule

`default_nettype wire

// *** verification/irq_prio_regs_chk.sv ***
// assertions on the priority register block's bus and level outputs
// bound to every irq_prio_regs instance; single clock domain
`timescale 1ns/10ps
`default_nettype none
module irq_prio_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // levels
  input wire logic [2:0]  timer4_level,
  input wire logic [2:0]  incap6_level,
  input wire logic [19:0] src_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire ack_w = avs_write && !avs_waitrequest;
  wire ack_r = avs_read && !avs_waitrequest;
  property p_rsv; ack_r && avs_address != 4'h5 |-> (avs_readdata & 32'hffff_8888) == 32'h0000_0000; endproperty
  a_rsv: assert property (p_rsv) else $error("unused read bits not zero");
  property p_rst; $rose(rst_n) |-> timer4_level == 3'h4 && src_enable == 20'hf_ffff; endproperty
  a_rst: assert property (p_rst) else $error("reset level wrong");
  property p_t4; ack_w && avs_address == 4'h0 && avs_byteenable[1] |-> timer4_level == avs_writedata[14:12]; endproperty
  a_t4: assert property (p_t4) else $error("timer4 field misplaced");
  property p_ic6; ack_w && avs_address == 4'h4 && avs_byteenable[0] |-> incap6_level == avs_writedata[2:0]; endproperty
  a_ic6: assert property (p_ic6) else $error("incap6 field misplaced");
  property p_hold; $changed(timer4_level) |-> ack_w && avs_address == 4'h0; endproperty
  a_hold: assert property (p_hold) else $error("level changed without write");
  property p_en; src_enable[19] == (timer4_level != 3'h0) && src_enable[0] == (incap6_level != 3'h0); endproperty
  a_en: assert property (p_en) else $error("enable does not follow level");
  property p_rb; ack_r && avs_address == 4'h0 |-> avs_readdata[14:12] == timer4_level; endproperty
  a_rb: assert property (p_rb) else $error("read back mismatch");
  property p_ans; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("answer longer than one cycle");
  c_wr: cover property (ack_w && avs_address == 4'h4);
  c_un: cover property (ack_r && avs_address == 4'h6);
  c_off: cover property (src_enable[0] == 1'b0);
  c_st: cover property (ack_r && avs_address == 4'h5);
endmodule
bind irq_prio_regs irq_prio_chk chk (.*);
`default_nettype wire

// *** verification/tb_irq_prio_regs.sv ***
// self-checking bench for irq_prio_regs
// bench is the avalon master; checker is bound from its own file
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_irq_prio_regs;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata, q;
  logic        avs_waitrequest;
  logic [2:0]  timer4_level, outcmp4_level, outcmp3_level, dma_ch2_done_level, uart2_tx_level, uart2_rx_level;
  logic [2:0]  ext_irq2_level, timer5_level, can1_event_level, can1_rx_ready_level, spi2_event_level;
  logic [2:0]  spi2_error_level, incap5_level, incap4_level, incap3_level, dma_ch3_done_level;
  logic [2:0]  outcmp7_level, outcmp6_level, outcmp5_level, incap6_level;
  logic [19:0] src_enable;
  int          num_errors = 0;
  int          comparisons = 0;
  logic [15:0] rw [5] = '{16'hffff, 16'h1234, 16'h8567, 16'h0000, 16'h7653};
  logic [15:0] re [5] = '{16'h7777, 16'h1234, 16'h0567, 16'h0000, 16'h7653};
  wire  [59:0] lv = {timer4_level, outcmp4_level, outcmp3_level, dma_ch2_done_level, uart2_tx_level,
    uart2_rx_level, ext_irq2_level, timer5_level, can1_event_level, can1_rx_ready_level, spi2_event_level,
    spi2_error_level, incap5_level, incap4_level, incap3_level, dma_ch3_done_level, outcmp7_level,
    outcmp6_level, outcmp5_level, incap6_level};
  irq_prio_regs dut (.*);
  always #5 core_clk = ~core_clk;
  task automatic finish_test;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one edge gap before raising, so a dropped request never meets a new one in one step
  task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) num_errors++;
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      acc(4'(k), 1'b1, {16'h0000, rw[k]}, 4'hf, q);
      acc(4'(k), 1'b0, 32'h0000_0000, 4'hf, q);
      `CHK(q, {16'h0000, re[k]})
      `CHK(lv[59-12*k -: 12], {re[k][14:12], re[k][10:8], re[k][6:4], re[k][2:0]})
      `CHK(src_enable[19-4*k -: 4], {|re[k][14:12], |re[k][10:8], |re[k][6:4], |re[k][2:0]})
    end
    $display("table test done");
    // lane 1 disabled: upper two fields must survive
    acc(4'h0, 1'b1, 32'hffff_0000, 4'h1, q);
    acc(4'h0, 1'b0, 32'h0000_0000, 4'hf, q);
    `CHK(q, 32'h0000_7700)
    acc(4'h6, 1'b1, 32'hffff_ffff, 4'hf, q);
    acc(4'h6, 1'b0, 32'h0000_0000, 4'hf, q);
    `CHK(q, 32'h0000_0000)
    // status word is read-only: the write must leave the enables of the earlier writes
    acc(4'h5, 1'b1, 32'hffff_ffff, 4'hf, q);
    acc(4'h5, 1'b0, 32'h0000_0000, 4'hf, q);
    `CHK(q, 32'h000c_f70f)
    $display("lane and unmapped test done");
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    `CHK({lv, src_enable}, {60'h924_9249_2492_4924, 20'hf_ffff})
    acc(4'h3, 1'b0, 32'h0000_0000, 4'hf, q);
    `CHK(q, 32'h0000_4444)
    $display("reset test done");
    finish_test();
  end
endmodule
`default_nettype wire
